//--- include/sapc_pkg.sv
// Behaviour
// RULE_01 - Not secret and not read-encrypted: clear reads of 4 or 32 bytes allowed.
// RULE_02 - Not secret yet read-encrypted is prohibited; configuring party must avoid it.
// RULE_03 - Secret and not read-encrypted: every read refused, slot still usable as key.
// RULE_04 - Secret and read-encrypted: reads encrypted with read-key slot; 4-byte access refused.
// RULE_05 - Slots holding ECC private keys are never readable.
// RULE_06 - Each command decodes the 4-bit write policy its own way, ignoring don't-cares.
// RULE_07 - Write with policy 0000 allows clear writes of 4 or 32 bytes.
// RULE_08 - Write with policy 0001 blocked while slot holds a validated public key.
// RULE_09 - Write with policy 001x or 10xx is always refused.
// RULE_10 - Policy bit 14 set: write needs MAC, encrypted with write-key slot, no 4-byte.
// RULE_11 - Policy bit 13 clear: slot may not be a key-derivation target.
// RULE_12 - Bit 12 picks derivation source: clear uses target, set uses write-key slot.
// RULE_13 - Policy bit 15 set: key derivation needs an authorizing MAC.
// RULE_14 - Interpretations overlap, so 0110 allows encrypted writes and unauthorized rolls.
// RULE_15 - Key generation only on ECC-kind slots, derivation only on SHA-256-kind slots.
// RULE_16 - ECC public key slots follow the plain write decoding.
// RULE_17 - Configuring party sets secret flag whenever policy is not always-writable.
// RULE_18 - Four-byte reads and writes of secret slots are refused.
// RULE_19 - Fixed keys should be secret, not read-encrypted and never-writable.
// RULE_20 - Key rotation: encrypt policy with write key pointing at itself, MAC by old key.
// RULE_21 - Read-key index sits in bits 3 to 0 and names the read encryption key.
// RULE_22 - Key generation allowed when policy bit 13 set, refused when clear.
// RULE_23 - Private-key load refused when bit 14 clear; else needs MAC and encryption.
// RULE_24 - Key generation or private-key load on non-private-key slots is an error.
// RULE_25 - Failed checks report an error and leave slot and output data untouched.
// RULE_26 - Decision is combinational from slot config and request, sampled before data moves.
package sapc_pkg;

  typedef enum logic [2:0] {
    cmd_read,
    cmd_write,
    cmd_derive,
    cmd_keygen,
    cmd_privload
  } sapc_cmd_e;

  localparam int SLOTS = 16;

  // Byte offsets on the APB
  localparam logic [11:0] OFF_REQ = 12'h000;
  localparam logic [11:0] OFF_RESULT = 12'h004;
  localparam logic [11:0] OFF_PUB_VALID = 12'h008;
  localparam logic [11:0] OFF_SLOT_BASE = 12'h040;
  localparam logic [11:0] OFF_KEY_BASE = 12'h080;

  // Slot policy word fields
  localparam int SP_READ_KEY_LSB = 0;
  localparam int SP_READ_ENC = 6;
  localparam int SP_SECRET = 7;
  localparam int SP_WKEY_LSB = 8;
  localparam int SP_WPOL_LSB = 12;
  // Bits inside the write policy field (policy bits 12..15)
  localparam int WP_PUBINV = 0;
  localparam int WP_B13 = 1;
  localparam int WP_ENC = 2;
  localparam int WP_AUTH = 3;

  // Key policy word fields
  localparam int KP_PRIVATE = 0;
  localparam int KP_KIND_LSB = 2;
  localparam logic [2:0] KIND_ECC = 3'h1;
  localparam logic [2:0] KIND_SHA = 3'h2;

  // Request register fields
  localparam int RQ_CMD_LSB = 0;
  localparam int RQ_SLOT_LSB = 4;
  localparam int RQ_SIZE32 = 8;
  localparam int RQ_MAC_OK = 9;

  // Result register fields
  localparam int RS_GRANT = 0;
  localparam int RS_ERROR = 1;
  localparam int RS_ENC = 2;
  localparam int RS_MAC_REQ = 3;
  localparam int RS_KEY_LSB = 4;
  localparam int RS_DONE = 8;

  // Reset values
  localparam logic [15:0] SLOT_CFG_RST = 16'h0000;
  localparam logic [7:0] KEY_CFG_RST = 8'h00;
  localparam logic [15:0] PUB_VALID_RST = 16'h0000;

  function automatic logic [3:0] sapc_wpol(input logic [15:0] cfg);
    sapc_wpol = cfg[SP_WPOL_LSB +: 4];
  endfunction

  function automatic logic sapc_is_private(input logic [7:0] kc);
    sapc_is_private = (kc[KP_KIND_LSB +: 3] == KIND_ECC) && kc[KP_PRIVATE];
  endfunction

endpackage

//--- hw/sapc_perm_decode.sv
`timescale 1ns/1ps
module sapc_perm_decode (
  input wire sapc_pkg::sapc_cmd_e cmd,
  input wire logic size32,
  input wire logic mac_ok,
  input wire logic [3:0] slot_idx,
  input wire logic [15:0] slot_cfg,
  input wire logic [7:0] key_cfg,
  input wire logic pub_valid,
  output logic grant,
  output logic encrypt,
  output logic mac_required,
  output logic [3:0] key_index
);

  logic secret;
  logic rd_enc;
  logic priv;
  logic [3:0] wp;
  logic [3:0] wkey;

  assign secret = slot_cfg[sapc_pkg::SP_SECRET];
  assign rd_enc = slot_cfg[sapc_pkg::SP_READ_ENC];
  assign priv = sapc_pkg::sapc_is_private(key_cfg);
  assign wp = sapc_pkg::sapc_wpol(slot_cfg); // [RULE_06]
  assign wkey = slot_cfg[sapc_pkg::SP_WKEY_LSB +: 4];

  // Purely combinational so the sequencer can sample it before moving data
  always_comb // [RULE_26]
  begin
    grant = 1'b0;
    encrypt = 1'b0;
    mac_required = 1'b0;
    key_index = 4'h0;
    case (cmd)
      sapc_pkg::cmd_read:
      begin
        // Prohibited 0/1 combination is treated as unreadable [RULE_02]
        if (!priv) // [RULE_05]
        begin
          if (!secret && !rd_enc)
            grant = 1'b1; // [RULE_01]
          else if (secret && rd_enc && size32) // [RULE_03] [RULE_04] [RULE_18]
          begin
            grant = 1'b1;
            encrypt = 1'b1;
            key_index = slot_cfg[sapc_pkg::SP_READ_KEY_LSB +: 4]; // [RULE_21]
          end
        end
      end
      sapc_pkg::cmd_write:
      begin
        // Public keys are plain data here; private keys never take this path [RULE_16]
        if (!priv)
        begin
          if (wp[sapc_pkg::WP_ENC]) // [RULE_10] [RULE_14]
          begin
            // Rotation works because the MAC key is whatever the write key names [RULE_20]
            if (size32 && mac_ok)
            begin
              grant = 1'b1;
              encrypt = 1'b1;
              mac_required = 1'b1;
              key_index = wkey;
            end
          end
          else if (wp == 4'h0 || (wp == 4'h1 && !pub_valid)) // [RULE_07] [RULE_08] [RULE_09]
            grant = size32 || !secret; // [RULE_18]
        end
      end
      sapc_pkg::cmd_derive:
      begin
        if (key_cfg[sapc_pkg::KP_KIND_LSB +: 3] == sapc_pkg::KIND_SHA
            && wp[sapc_pkg::WP_B13] // [RULE_11] [RULE_15]
            && (!wp[sapc_pkg::WP_AUTH] || mac_ok)) // [RULE_13]
        begin
          grant = 1'b1;
          mac_required = wp[sapc_pkg::WP_AUTH];
          key_index = wp[sapc_pkg::WP_PUBINV] ? wkey : slot_idx; // [RULE_12] [RULE_14]
        end
      end
      sapc_pkg::cmd_keygen:
        grant = priv && wp[sapc_pkg::WP_B13]; // [RULE_15] [RULE_22] [RULE_24]
      sapc_pkg::cmd_privload:
      begin
        if (priv && wp[sapc_pkg::WP_ENC] && mac_ok && size32) // [RULE_23] [RULE_24]
        begin
          grant = 1'b1;
          encrypt = 1'b1;
          mac_required = 1'b1;
          key_index = wkey;
        end
      end
      default:
        grant = 1'b0;
    endcase
  end

endmodule

//--- hw/sapc_slot_perm.sv
`timescale 1ns/1ps
module sapc_slot_perm (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic perm_done,
  output logic perm_grant,
  output logic perm_error,
  output logic perm_encrypt,
  output logic perm_mac_required,
  output logic [3:0] perm_key_index
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [15:0] slot_cfg [sapc_pkg::SLOTS];
  logic [7:0] key_cfg [sapc_pkg::SLOTS];
  logic [15:0] pub_valid;
  sapc_pkg::sapc_cmd_e req_cmd;
  logic [3:0] req_slot;
  logic req_size32;
  logic req_mac_ok;
  logic eval;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic setup;
  logic access;
  logic wr_en;
  logic hit_req;
  logic hit_res;
  logic hit_pub;
  logic hit_slot;
  logic hit_key;
  logic mapped;
  logic [3:0] idx;
  logic [31:0] next_rdata;

  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign idx = paddr[5:2];
  assign hit_req = paddr == sapc_pkg::OFF_REQ;
  assign hit_res = paddr == sapc_pkg::OFF_RESULT;
  assign hit_pub = paddr == sapc_pkg::OFF_PUB_VALID;
  assign hit_slot = paddr[11:6] == sapc_pkg::OFF_SLOT_BASE[11:6] && paddr[1:0] == 2'h0;
  assign hit_key = paddr[11:6] == sapc_pkg::OFF_KEY_BASE[11:6] && paddr[1:0] == 2'h0;
  assign mapped = hit_req || hit_res || hit_pub || hit_slot || hit_key;
  assign wr_en = access && pwrite && mapped;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (hit_req)
    begin
      next_rdata[sapc_pkg::RQ_CMD_LSB +: 3] = req_cmd;
      next_rdata[sapc_pkg::RQ_SLOT_LSB +: 4] = req_slot;
      next_rdata[sapc_pkg::RQ_SIZE32] = req_size32;
      next_rdata[sapc_pkg::RQ_MAC_OK] = req_mac_ok;
    end
    else if (hit_res)
    begin
      next_rdata[sapc_pkg::RS_GRANT] = perm_grant;
      next_rdata[sapc_pkg::RS_ERROR] = perm_error;
      next_rdata[sapc_pkg::RS_ENC] = perm_encrypt;
      next_rdata[sapc_pkg::RS_MAC_REQ] = perm_mac_required;
      next_rdata[sapc_pkg::RS_KEY_LSB +: 4] = perm_key_index;
      next_rdata[sapc_pkg::RS_DONE] = perm_done;
    end
    else if (hit_pub)
      next_rdata[15:0] = pub_valid;
    else if (hit_slot)
      next_rdata[15:0] = slot_cfg[idx];
    else if (hit_key)
      next_rdata[7:0] = key_cfg[idx];
  end

  // No wait state: pready is registered from the setup phase, so every bus output is a plain flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup)
        prdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < sapc_pkg::SLOTS; i++)
      begin
        slot_cfg[i] <= sapc_pkg::SLOT_CFG_RST;
        key_cfg[i] <= sapc_pkg::KEY_CFG_RST;
      end
      pub_valid <= sapc_pkg::PUB_VALID_RST;
    end
    else if (wr_en)
    begin
      if (hit_slot)
        slot_cfg[idx] <= pwdata[15:0];
      if (hit_key)
        key_cfg[idx] <= pwdata[7:0];
      if (hit_pub)
        pub_valid <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request capture

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_cmd <= sapc_pkg::cmd_read;
      req_slot <= 4'h0;
      req_size32 <= 1'b0;
      req_mac_ok <= 1'b0;
      eval <= 1'b0;
    end
    else
    begin
      eval <= wr_en && hit_req;
      if (wr_en && hit_req)
      begin
        req_cmd <= sapc_pkg::sapc_cmd_e'(pwdata[sapc_pkg::RQ_CMD_LSB +: 3]);
        req_slot <= pwdata[sapc_pkg::RQ_SLOT_LSB +: 4];
        req_size32 <= pwdata[sapc_pkg::RQ_SIZE32];
        req_mac_ok <= pwdata[sapc_pkg::RQ_MAC_OK];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Permission decision

  logic [15:0] cur_cfg;
  logic [7:0] cur_kc;
  logic [3:0] cur_wp;
  logic cur_priv;
  logic dec_grant;
  logic dec_encrypt;
  logic dec_mac_required;
  logic [3:0] dec_key_index;
  logic res_clear;

  assign cur_cfg = slot_cfg[req_slot];
  assign cur_kc = key_cfg[req_slot];
  assign cur_wp = sapc_pkg::sapc_wpol(cur_cfg);
  assign cur_priv = sapc_pkg::sapc_is_private(cur_kc);
  assign res_clear = wr_en && hit_res && pwdata[sapc_pkg::RS_DONE];

  sapc_perm_decode u_decode (
    .cmd(req_cmd),
    .size32(req_size32),
    .mac_ok(req_mac_ok),
    .slot_idx(req_slot),
    .slot_cfg(cur_cfg),
    .key_cfg(cur_kc),
    .pub_valid(pub_valid[req_slot]),
    .grant(dec_grant),
    .encrypt(dec_encrypt),
    .mac_required(dec_mac_required),
    .key_index(dec_key_index)
  );

  // Sampled once per request; later config writes do not alter a given answer
  always_ff @(posedge pclk or negedge presetn) // [RULE_26]
  begin
    if (!presetn)
    begin
      perm_grant <= 1'b0;
      perm_error <= 1'b0;
      perm_encrypt <= 1'b0;
      perm_mac_required <= 1'b0;
      perm_key_index <= 4'h0;
    end
    else if (eval)
    begin
      perm_grant <= dec_grant;
      perm_error <= !dec_grant; // [RULE_25]
      perm_encrypt <= dec_encrypt;
      perm_mac_required <= dec_mac_required;
      perm_key_index <= dec_key_index;
    end
  end

  // Done flag: a new result beats a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      perm_done <= 1'b0;
    else if (eval)
      perm_done <= 1'b1;
    else if (res_clear)
      perm_done <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_eval(sapc_pkg::sapc_cmd_e c);
    eval && req_cmd == c;
  endsequence

  sequence s_read_open;
    s_eval(sapc_pkg::cmd_read) ##0 !cur_priv;
  endsequence

  sequence s_plain_write;
    s_eval(sapc_pkg::cmd_write) ##0 !cur_priv && !cur_wp[sapc_pkg::WP_ENC];
  endsequence

  a_read_clear_ok: assert property ( // [RULE_01]
    s_read_open ##0 !cur_cfg[sapc_pkg::SP_SECRET] && !cur_cfg[sapc_pkg::SP_READ_ENC]
    |=> perm_grant && !perm_encrypt)
    else $error("clear read refused");

  a_read_bad_combo: assert property ( // [RULE_02]
    s_eval(sapc_pkg::cmd_read) ##0 !cur_cfg[sapc_pkg::SP_SECRET]
    && cur_cfg[sapc_pkg::SP_READ_ENC] |=> perm_error)
    else $error("prohibited combination readable");

  a_read_secret_deny: assert property ( // [RULE_03]
    s_eval(sapc_pkg::cmd_read) ##0 cur_cfg[sapc_pkg::SP_SECRET]
    && !cur_cfg[sapc_pkg::SP_READ_ENC] |=> perm_error && !perm_grant)
    else $error("secret slot readable");

  a_read_enc_key: assert property ( // [RULE_04]
    s_read_open ##0 cur_cfg[sapc_pkg::SP_SECRET] && cur_cfg[sapc_pkg::SP_READ_ENC]
    && req_size32 |=> perm_grant && perm_encrypt
    && perm_key_index == $past(cur_cfg[3:0])) // [RULE_21]
    else $error("encrypted read wrong");

  a_read_priv_deny: assert property ( // [RULE_05]
    s_eval(sapc_pkg::cmd_read) ##0 cur_priv |=> perm_error)
    else $error("private key readable");

  a_short_secret: assert property ( // [RULE_18]
    eval && cur_cfg[sapc_pkg::SP_SECRET] && !req_size32
    && (req_cmd == sapc_pkg::cmd_read || req_cmd == sapc_pkg::cmd_write)
    |=> perm_error)
    else $error("4-byte secret access granted");

  a_write_always: assert property ( // [RULE_07]
    s_plain_write ##0 cur_wp == 4'h0 && !cur_cfg[sapc_pkg::SP_SECRET] |=> perm_grant)
    else $error("always-writable slot refused");

  a_write_pubinv: assert property ( // [RULE_08]
    s_plain_write ##0 cur_wp == 4'h1 && (req_size32 || !cur_cfg[sapc_pkg::SP_SECRET])
    |=> perm_error == $past(pub_valid[req_slot]))
    else $error("validated key write wrong");

  a_write_never: assert property ( // [RULE_09]
    s_plain_write ##0 (cur_wp[3:1] == 3'h1 || cur_wp[3:2] == 2'h2) |=> perm_error)
    else $error("never slot writable");

  a_write_enc: assert property ( // [RULE_10]
    s_eval(sapc_pkg::cmd_write) ##0 !cur_priv && cur_wp[sapc_pkg::WP_ENC]
    |=> perm_grant == $past(req_size32 && req_mac_ok) && perm_encrypt == perm_grant)
    else $error("encrypted write check wrong");

  a_derive_gate: assert property ( // [RULE_11]
    s_eval(sapc_pkg::cmd_derive) ##0 (!cur_wp[sapc_pkg::WP_B13]
    || cur_kc[sapc_pkg::KP_KIND_LSB +: 3] != sapc_pkg::KIND_SHA) |=> perm_error) // [RULE_15]
    else $error("derive target not allowed");

  a_derive_source: assert property ( // [RULE_12]
    s_eval(sapc_pkg::cmd_derive) ##1 perm_grant |-> perm_key_index
    == ($past(cur_wp[0]) ? $past(cur_cfg[11:8]) : $past(req_slot)))
    else $error("derive source wrong");

  a_derive_mac: assert property ( // [RULE_13]
    s_eval(sapc_pkg::cmd_derive) ##0 cur_wp[sapc_pkg::WP_AUTH] && !req_mac_ok
    |=> perm_error)
    else $error("derive ran without MAC");

  a_keygen_gate: assert property ( // [RULE_22]
    s_eval(sapc_pkg::cmd_keygen) |=> perm_grant == $past(cur_priv && cur_wp[1])) // [RULE_24]
    else $error("key generation gate wrong");

  a_privload_gate: assert property ( // [RULE_23]
    s_eval(sapc_pkg::cmd_privload) ##0 (!cur_priv || !cur_wp[sapc_pkg::WP_ENC])
    |=> perm_error) // [RULE_24]
    else $error("private load accepted");

  a_fail_quiet: assert property ( // [RULE_25]
    perm_error |-> !perm_grant && !perm_encrypt && !perm_mac_required
    && perm_key_index == 4'h0)
    else $error("refused result carries data");

  a_done_sticky: assert property (
    eval |=> perm_done ##1 (perm_done || $past(res_clear)))
    else $error("done flag lost");

  a_apb_answer: assert property (
    setup |=> pready ##1 !pready)
    else $error("bus answer timing wrong");

endmodule

//--- bench/sapc_cmd_model.sv
`timescale 1ns/1ps
module sapc_cmd_model (
  input wire logic pclk,
  input wire logic presetn,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One request at a time; the sequencer never overlaps two transfers
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed here; the bench watchdog ends a hung wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines do not keep the last value, so stale data cannot pass
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

//--- bench/slot_access_permission_check_tb_top.sv
`timescale 1ns/1ps
module slot_access_permission_check_tb_top;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic perm_done;
  logic perm_grant;
  logic perm_error;
  logic perm_encrypt;
  logic perm_mac_required;
  logic [3:0] perm_key_index;
  int fails;
  int total_checks;
  localparam logic [15:0] PUB_MASK = 16'h0080;

  sapc_slot_perm uut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .perm_done(perm_done),
    .perm_grant(perm_grant),
    .perm_error(perm_error),
    .perm_encrypt(perm_encrypt),
    .perm_mac_required(perm_mac_required),
    .perm_key_index(perm_key_index)
  );

  sapc_cmd_model bfm (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    bfm.xfer(1'b1, a, d, rd, er);
    check({31'h0, er}, 32'h0);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    logic [31:0] rd;
    logic er;
    bfm.xfer(1'b0, a, 32'h0, rd, er);
    check(rd, exp);
    check({31'h0, er}, {31'h0, eerr});
  endtask

  function automatic logic [31:0] outs();
    return {23'h0, perm_done, perm_key_index, perm_mac_required, perm_encrypt,
            perm_error, perm_grant};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reference decision: {key index, mac required, encrypt, error, grant}
  function automatic logic [7:0] exp_res(input logic [3:0] s, input logic [15:0] c,
                                         input logic [7:0] k, input logic [2:0] cmd,
                                         input logic sz, input logic mac);
    logic p;
    logic [3:0] w;
    logic g;
    logic e;
    logic m;
    logic [3:0] ki;
    p = (k[4:2] == sapc_pkg::KIND_ECC) && k[0];
    w = c[15:12];
    case (cmd)
      3'h0: g = !p && (c[7:6] == 2'b00 || (c[7:6] == 2'b11 && sz));
      3'h1: g = !p && (sz || !c[7]) && (w[2] ? (sz && mac) : (w == 4'h0 ||
                (w == 4'h1 && !PUB_MASK[s])));
      3'h2: g = (k[4:2] == sapc_pkg::KIND_SHA) && w[1] && (!w[3] || mac);
      3'h3: g = p && w[1];
      3'h4: g = p && w[2] && sz && mac;
      default: g = 1'b0;
    endcase
    e = g && (cmd == 3'h0 ? c[6] : cmd == 3'h1 ? w[2] : cmd == 3'h4);
    m = g && (cmd == 3'h1 ? w[2] : cmd == 3'h2 ? w[3] : cmd == 3'h4);
    ki = !g ? 4'h0 : cmd == 3'h0 ? (c[6] ? c[3:0] : 4'h0) : (cmd == 3'h2 && !w[0]) ? s :
         (cmd == 3'h3 || (cmd == 3'h1 && !w[2])) ? 4'h0 : c[11:8];
    return {ki, m, e, !g, g};
  endfunction

  task automatic run(input logic [3:0] s, input logic [15:0] c, input logic [7:0] k,
                     input logic [2:0] cmd, input logic sz, input logic mac);
    logic [7:0] e;
    e = exp_res(s, c, k, cmd, sz, mac);
    wr(sapc_pkg::OFF_SLOT_BASE + {6'h00, s, 2'b00}, {16'h0, c});
    wr(sapc_pkg::OFF_KEY_BASE + {6'h00, s, 2'b00}, {24'h0, k});
    wr(sapc_pkg::OFF_REQ, {22'h0, mac, sz, s, 1'b0, cmd});
    // Decision lands one edge after the request is taken
    @(posedge pclk);
    #1;
    check(outs(), {23'h0, 1'b1, e});
    rd_chk(sapc_pkg::OFF_RESULT, {23'h0, 1'b1, e}, 1'b0);
    wr(sapc_pkg::OFF_RESULT, 32'h0000_0100);
    rd_chk(sapc_pkg::OFF_RESULT, {24'h0, e}, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6000) @(posedge pclk);
    fails++;
    end_of_test();
  end

  initial
  begin
    fails = 0;
    total_checks = 0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    check(outs(), 32'h0);
    rd_chk(sapc_pkg::OFF_SLOT_BASE + 12'h00C, {16'h0, sapc_pkg::SLOT_CFG_RST}, 1'b0);
    rd_chk(sapc_pkg::OFF_KEY_BASE + 12'h00C, {24'h0, sapc_pkg::KEY_CFG_RST}, 1'b0);
    rd_chk(sapc_pkg::OFF_PUB_VALID, {16'h0, sapc_pkg::PUB_VALID_RST}, 1'b0);
    rd_chk(sapc_pkg::OFF_RESULT, 32'h0, 1'b0);
    rd_chk(12'h00C, 32'h0, 1'b1);
    rd_chk(12'h042, 32'h0, 1'b1);
    wr(sapc_pkg::OFF_PUB_VALID, {16'h0, PUB_MASK});
    rd_chk(sapc_pkg::OFF_PUB_VALID, {16'h0, PUB_MASK}, 1'b0);
    run(4'h1, 16'h0000, 8'h00, 3'h0, 1'b0, 1'b0);
    run(4'h1, 16'h0000, 8'h04, 3'h0, 1'b1, 1'b0);
    run(4'h2, 16'h0040, 8'h00, 3'h0, 1'b1, 1'b0);
    run(4'h3, 16'h2080, 8'h08, 3'h0, 1'b1, 1'b0);
    run(4'h4, 16'h20C5, 8'h08, 3'h0, 1'b1, 1'b0);
    run(4'h4, 16'h20C5, 8'h08, 3'h0, 1'b0, 1'b0);
    run(4'h5, 16'h20C5, 8'h05, 3'h0, 1'b1, 1'b0);
    run(4'h6, 16'h0000, 8'h00, 3'h1, 1'b0, 1'b0);
    run(4'h7, 16'h1080, 8'h04, 3'h1, 1'b1, 1'b0);
    run(4'h8, 16'h1080, 8'h04, 3'h1, 1'b1, 1'b0);
    run(4'h9, 16'h2080, 8'h08, 3'h1, 1'b1, 1'b1);
    run(4'h9, 16'h3080, 8'h08, 3'h1, 1'b1, 1'b1);
    run(4'h9, 16'h8080, 8'h08, 3'h1, 1'b1, 1'b1);
    run(4'h9, 16'hB080, 8'h08, 3'h1, 1'b1, 1'b1);
    run(4'hA, 16'h4A80, 8'h08, 3'h1, 1'b1, 1'b1);
    run(4'hA, 16'h4A80, 8'h08, 3'h1, 1'b1, 1'b0);
    run(4'hA, 16'h4A80, 8'h08, 3'h1, 1'b0, 1'b1);
    run(4'hA, 16'hCA80, 8'h08, 3'h1, 1'b1, 1'b1);
    run(4'hB, 16'h6380, 8'h08, 3'h1, 1'b1, 1'b1);
    run(4'hB, 16'h6380, 8'h08, 3'h2, 1'b1, 1'b1);
    run(4'hC, 16'h3380, 8'h08, 3'h2, 1'b0, 1'b0);
    run(4'hC, 16'hA380, 8'h08, 3'h2, 1'b1, 1'b1);
    run(4'hC, 16'hA380, 8'h08, 3'h2, 1'b1, 1'b0);
    run(4'hC, 16'hB380, 8'h08, 3'h2, 1'b1, 1'b1);
    run(4'hC, 16'hD380, 8'h08, 3'h2, 1'b1, 1'b1);
    run(4'hC, 16'h3380, 8'h04, 3'h2, 1'b1, 1'b1);
    run(4'h0, 16'h2380, 8'h05, 3'h3, 1'b1, 1'b0);
    run(4'h0, 16'hD080, 8'h05, 3'h3, 1'b1, 1'b0);
    run(4'h0, 16'h2080, 8'h08, 3'h3, 1'b1, 1'b0);
    run(4'h0, 16'h2080, 8'h04, 3'h3, 1'b1, 1'b0);
    run(4'hD, 16'h4380, 8'h05, 3'h4, 1'b1, 1'b1);
    run(4'hD, 16'hB380, 8'h05, 3'h4, 1'b1, 1'b1);
    run(4'hD, 16'h4380, 8'h04, 3'h4, 1'b1, 1'b1);
    run(4'hD, 16'h0000, 8'h05, 3'h1, 1'b1, 1'b1);
    for (int i = 5; i < 8; i++)
      run(4'h1, 16'h0000, 8'h00, 3'(i), 1'b1, 1'b1);
    end_of_test();
  end
endmodule
